// ==== src/twi_slave_pkg.sv ====
// shared constants and types for the two-wire register access slave
// assumes a 10 MHz mclk sampling a master-driven serial clock
package twi_slave_pkg;
   localparam logic [6:0] DEFAULT_ADDR    = 7'h10;
   localparam logic [7:0] WRITE_ADDR_BYTE = 8'h20;
   localparam logic [7:0] READ_ADDR_BYTE  = 8'h21;
   localparam int         BYTE_BITS       = 8;
   localparam logic [2:0] LAST_BIT        = 3'h7;
   localparam logic [15:0] PTR_RESET      = 16'h0000;
   localparam int         SYNC_STAGES     = 2;

   typedef enum logic [2:0] {
      ST_IDLE, ST_DEVADDR, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_RDATA, ST_IGNORE
   } phase_e;

   // register-side access carried to the register file
   typedef struct packed {
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  data;
   } reg_wr_s;
endpackage

// ==== src/twi_slave.sv ====
// two-wire register access slave: address pointer, reads and writes
// assumes serial clock and data arrive asynchronously and are oversampled by mclk
`timescale 1ns/1ps

// What this block does
// - device shifts read data byte-wise; master acknowledges to continue
// - internal address pointer increments after every transferred data byte
// - master no-acknowledge ends read data; data line released
// - dummy write of register address loads pointer before random read
// - read without address phase returns data at current pointer
// - sequential read continues while master acknowledges each byte
// - sequential write stores each byte at incremented address
// - respond to 0x20 write and 0x21 read; bit zero selects direction
// - acknowledge a matching device address, each register address byte and each write data byte by pulling data low; read data bytes are left to the master
// - serial clock is input only, never stretched
// - bytes msb first; data changes only while clock is low
module twi_slave (
   // clock, enable, reset
   input  wire logic                  mclk,
   input  wire logic                  clk_en,
   input  wire logic                  rst_b,
   // serial bus pins
   input  wire logic                  serial_bus_clock_in,
   input  wire logic                  serial_bus_data_in,
   output logic                       serial_bus_data_out,
   output logic                       serial_bus_data_oe,
   // register file side
   output twi_slave_pkg::reg_wr_s     reg_wr,
   output logic [15:0]                reg_rd_addr,
   input  wire logic [7:0]            reg_rd_data
);
   // two stages plus one history stage per pin
   logic [2:0] scl_q;
   logic [2:0] sda_q;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else if (clk_en) begin
         scl_q <= {scl_q[1:0], serial_bus_clock_in};
         sda_q <= {sda_q[1:0], serial_bus_data_in};
      end
   end

   wire scl      = scl_q[1];
   wire sda      = sda_q[1];
   wire scl_rise = scl_q[1] & ~scl_q[2];
   wire scl_fall = ~scl_q[1] & scl_q[2];
   wire start_c  = scl & scl_q[2] & ~sda & sda_q[2];
   wire stop_c   = scl & scl_q[2] & sda & ~sda_q[2];

   twi_slave_pkg::phase_e phase;
   logic [7:0]  shift;
   logic [2:0]  bit_cnt;
   logic        ack_slot;          // in the ninth bit period
   logic        pending_ack_done;  // first fall of the ninth bit already handled
   logic        is_read;
   logic [15:0] ptr;
   logic        drive_low;

   // phase to enter once the ninth bit period has ended
   function automatic twi_slave_pkg::phase_e after_ack(input twi_slave_pkg::phase_e p,
                                                       input logic             rd);
      if (p == twi_slave_pkg::ST_DEVADDR && rd) begin
         after_ack = twi_slave_pkg::ST_RDATA;
      end else if (p == twi_slave_pkg::ST_DEVADDR) begin
         after_ack = twi_slave_pkg::ST_ADDR_HI;
      end else if (p == twi_slave_pkg::ST_ADDR_HI) begin
         after_ack = twi_slave_pkg::ST_ADDR_LO;
      end else if (p == twi_slave_pkg::ST_ADDR_LO) begin
         after_ack = twi_slave_pkg::ST_WDATA;
      end else begin
         after_ack = p;
      end
   endfunction

   // ninth bit has two falls: the first opens the ack, the second closes it
   wire [7:0] rx_byte   = {shift[6:0], sda};
   wire       in_read   = phase == twi_slave_pkg::ST_RDATA;
   wire       in_rx     = phase == twi_slave_pkg::ST_DEVADDR || phase == twi_slave_pkg::ST_ADDR_HI
                          || phase == twi_slave_pkg::ST_ADDR_LO || phase == twi_slave_pkg::ST_WDATA;
   wire       busy      = in_rx | in_read;
   wire       byte_done = scl_rise & ~ack_slot & (bit_cnt == twi_slave_pkg::LAST_BIT);
   wire       ack_open  = scl_fall & ack_slot & ~pending_ack_done;
   wire       ack_close = scl_fall & ack_slot & pending_ack_done;
   wire       tx_step   = scl_fall & ~ack_slot & in_read;
   wire       nack_seen = scl_rise & ack_slot & in_read & sda;
   wire       rd_load   = in_read | (phase == twi_slave_pkg::ST_DEVADDR & is_read);
   wire       addr_hit  = rx_byte[7:1] == twi_slave_pkg::DEFAULT_ADDR;
   wire       tx_bit    = shift[7];

   assign reg_rd_addr = ptr;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pending_ack_done <= 1'b0;
      end else if (clk_en) begin
         if (byte_done || start_c || stop_c) begin
            pending_ack_done <= 1'b0;
         end else if (scl_fall && ack_slot) begin
            pending_ack_done <= 1'b1;
         end
      end
   end

   // data line only moves after the clock has fallen
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         phase     <= twi_slave_pkg::ST_IDLE;
         shift     <= 8'h00;
         bit_cnt   <= 3'h0;
         ack_slot  <= 1'b0;
         is_read   <= 1'b0;
         ptr       <= twi_slave_pkg::PTR_RESET;
         drive_low <= 1'b0;
         reg_wr    <= '0;
      end else if (clk_en) begin
         reg_wr.wr <= 1'b0;
         if (start_c) begin
            phase     <= twi_slave_pkg::ST_DEVADDR;
            bit_cnt   <= 3'h0;
            ack_slot  <= 1'b0;
            drive_low <= 1'b0;
         end else if (stop_c) begin
            phase     <= twi_slave_pkg::ST_IDLE;
            ack_slot  <= 1'b0;
            drive_low <= 1'b0;
         end else if (busy) begin
            if (scl_rise && !ack_slot) begin
               bit_cnt <= bit_cnt + 3'h1;
            end
            if (scl_rise && !ack_slot && !in_read) begin
               shift <= rx_byte;
            end
            if (byte_done) begin
               ack_slot <= 1'b1;
               unique case (phase)
                  twi_slave_pkg::ST_DEVADDR: begin
                     if (!addr_hit) begin
                        phase <= twi_slave_pkg::ST_IGNORE;
                     end else begin
                        is_read <= rx_byte[0];
                     end
                  end
                  twi_slave_pkg::ST_ADDR_HI: ptr[15:8] <= rx_byte;
                  twi_slave_pkg::ST_ADDR_LO: ptr[7:0]  <= rx_byte;
                  twi_slave_pkg::ST_WDATA: begin
                     reg_wr <= '{wr: 1'b1, addr: ptr, data: rx_byte};
                     ptr    <= ptr + 16'h0001;
                  end
                  twi_slave_pkg::ST_RDATA: begin
                     ptr <= ptr + 16'h0001;
                  end
                  default: ;
               endcase
            end
            if (nack_seen) begin
               phase <= twi_slave_pkg::ST_IGNORE;
            end
            if (ack_open) begin
               drive_low <= ~in_read;
            end else if (ack_close) begin
               ack_slot <= 1'b0;
               phase    <= after_ack(phase, is_read);
               if (rd_load) begin
                  shift     <= reg_rd_data << 1;
                  drive_low <= ~reg_rd_data[7];
               end else begin
                  drive_low <= 1'b0;
               end
            end else if (tx_step) begin
               shift     <= shift << 1;
               drive_low <= ~tx_bit;
            end
         end else begin
            drive_low <= 1'b0;
         end
      end
   end

   // open drain: only ever pull low; clock pin has no driver at all
   assign serial_bus_data_out = 1'b0;
   assign serial_bus_data_oe  = drive_low;

   chk_no_drive_idle: assert property (@(posedge mclk) disable iff (!rst_b)
      phase == twi_slave_pkg::ST_IDLE |=> !serial_bus_data_oe || !$past(clk_en))
      else $error("data line driven while idle");
   chk_ptr_step: assert property (@(posedge mclk) disable iff (!rst_b)
      reg_wr.wr |-> ptr == reg_wr.addr + 16'h0001)
      else $error("pointer did not advance after write");
   chk_stop_release: assert property (@(posedge mclk) disable iff (!rst_b)
      clk_en && stop_c |=> !serial_bus_data_oe && phase == twi_slave_pkg::ST_IDLE)
      else $error("line not released after stop");
   chk_start_addr: assert property (@(posedge mclk) disable iff (!rst_b)
      clk_en && start_c |=> phase == twi_slave_pkg::ST_DEVADDR && !reg_wr.wr)
      else $error("start not honoured");
   chk_oe_stable_high: assert property (@(posedge mclk) disable iff (!rst_b)
      clk_en && scl && scl_q[2] && !start_c && !stop_c && $past(clk_en)
      |-> $stable(serial_bus_data_oe))
      else $error("data line changed while clock high");
   chk_ignore_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
      phase == twi_slave_pkg::ST_IGNORE |=> !serial_bus_data_oe)
      else $error("ignored transfer drives line");
   chk_nack_ends: assert property (@(posedge mclk) disable iff (!rst_b)
      clk_en && scl_rise && ack_slot && sda && !stop_c && !start_c
      && phase == twi_slave_pkg::ST_RDATA |=> phase == twi_slave_pkg::ST_IGNORE)
      else $error("read continued past nack");
   chk_write_data: assert property (@(posedge mclk) disable iff (!rst_b)
      reg_wr.wr |-> $past(phase) == twi_slave_pkg::ST_WDATA)
      else $error("write outside data phase");
   chk_ack_drive: assert property (@(posedge mclk) disable iff (!rst_b)
      clk_en && busy && ack_open && !in_read |=> serial_bus_data_oe)
      else $error("received byte not acknowledged");
   chk_read_release: assert property (@(posedge mclk) disable iff (!rst_b)
      clk_en && busy && ack_open && in_read |=> !serial_bus_data_oe)
      else $error("line held during master ack bit");
   chk_ack_release: assert property (@(posedge mclk) disable iff (!rst_b)
      clk_en && busy && ack_close && !rd_load |=> !serial_bus_data_oe)
      else $error("ack held past ninth bit");
   chk_freeze_hold: assert property (@(posedge mclk) disable iff (!rst_b)
      !clk_en |=> $stable(ptr) && $stable(phase))
      else $error("state moved while clock enable low");
endmodule

// ==== sim/twi_master.sv ====
// behavioural two-wire bus master: serial clock, open-drain data drive, read capture
// assumes the bench resolves the data wire with a pull-up from both enables
`timescale 1ns/1ps
module twi_master (
   // resolved data wire
   input  wire logic       sda_in,
   // master drive
   output logic            scl,
   output logic            sda_oe,
   // read result, toggles once per byte
   output logic [7:0]      rd_byte,
   output logic            rd_pulse
);
   localparam int Q = 200;
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
      rd_byte = 8'h00;
      rd_pulse = 1'b0;
   end
   // data moves a quarter period after the fall, sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      sda_oe <= ~b;
      #Q scl <= 1'b1;
      #Q r = sda_in;
      #Q scl <= 1'b0;
      #Q;
   endtask
   // also a repeated start when entered with the clock low
   task automatic start();
      sda_oe <= 1'b0;
      #Q scl <= 1'b1;
      #Q sda_oe <= 1'b1;
      #Q scl <= 1'b0;
      #Q;
   endtask
   // clock then stands high until the next frame
   task automatic stop();
      sda_oe <= 1'b1;
      #Q scl <= 1'b1;
      #Q sda_oe <= 1'b0;
      #Q;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // ack to go on, release to end the read
   task automatic rbyte(input logic ack);
      logic       r;
      logic [7:0] d;
      d = 8'h00;
      for (int i = 0; i < 8; i++) begin
         bit_io(1'b1, r);
         d = {d[6:0], r};
      end
      bit_io(~ack, r);
      rd_byte = d;
      rd_pulse = ~rd_pulse;
   endtask
endmodule

// ==== sim/twi_slave_tb.sv ====
// bench for the two-wire register slave: master model, register array, queued checks
// assumes the slave sits behind a pull-up data wire and a byte-wide register array
`timescale 1ns/1ps
module twi_slave_tb;
   logic                   mclk = 1'b0;
   logic                   rst_b = 1'b0;
   logic                   clk_en = 1'b1;
   logic                   scl, m_oe, dut_do, dut_oe, rp, junk;
   logic [7:0]             rbyte_v;
   wire logic              sda;
   twi_slave_pkg::reg_wr_s reg_wr;
   logic [15:0]            reg_rd_addr, ptr;
   logic [7:0]             mem [0:255];
   logic [7:0]             em [0:255];
   logic [23:0]            wq[$];
   logic [7:0]             rq[$];
   int                     n_fail = 0;
   int                     compares = 0;
   int                     cyc = 0;
   always #50 mclk = ~mclk;
   assign sda = (dut_oe ? dut_do : 1'b1) & ~m_oe;
   twi_master i_m (.sda_in(sda), .scl(scl), .sda_oe(m_oe), .rd_byte(rbyte_v), .rd_pulse(rp));
   twi_slave i_dut (.mclk(mclk), .clk_en(clk_en), .rst_b(rst_b), .serial_bus_clock_in(scl),
      .serial_bus_data_in(sda), .serial_bus_data_out(dut_do), .serial_bus_data_oe(dut_oe),
      .reg_wr(reg_wr), .reg_rd_addr(reg_rd_addr), .reg_rd_data(mem[reg_rd_addr[7:0]]));
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         results();
      end
      if (reg_wr.wr === 1'b1) begin
         mem[reg_wr.addr[7:0]] <= reg_wr.data;
         if (wq.size() == 0) check({reg_wr.addr, reg_wr.data}, 24'hffffff);
         else check({reg_wr.addr, reg_wr.data}, wq.pop_front());
      end
   end
   always @(rp) if (rst_b === 1'b1) begin
      if (rq.size() == 0) check({16'h0, rbyte_v}, 24'hffffff);
      else check({16'h0, rbyte_v}, {16'h0, rq.pop_front()});
   end
   task automatic wb(input logic [7:0] d, input logic exp);
      logic ack;
      i_m.wbyte(d, ack);
      check({23'h0, ack}, {23'h0, exp});
   endtask
   task automatic addr_phase(input logic [15:0] a);
      i_m.start();
      wb(8'h20, 1'b1);
      wb(a[15:8], 1'b1);
      wb(a[7:0], 1'b1);
      ptr = a;
   endtask
   task automatic wr(input logic [15:0] a, input int n);
      logic [7:0] d;
      addr_phase(a);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom());
         em[a[7:0] + 8'(i)] = d;
         wq.push_back({a + 16'(i), d});
         wb(d, 1'b1);
      end
      i_m.stop();
      ptr = a + 16'(n);
   endtask
   task automatic rd(input logic set, input logic [15:0] a, input int n);
      if (set) addr_phase(a);
      i_m.start();
      wb(8'h21, 1'b1);
      for (int i = 0; i < n; i++) begin
         rq.push_back(em[ptr[7:0]]);
         ptr = ptr + 16'h0001;
         i_m.rbyte(i < n - 1);
      end
      i_m.stop();
      check({23'h0, dut_oe}, 24'h0);
   endtask
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h5a;
         em[i] = 8'(i) ^ 8'h5a;
      end
      void'($urandom(32'hb431));
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      wr(16'h0010, 1);
      wr(16'h00fe, 4);
      rd(1'b1, 16'h0010, 1);
      rd(1'b1, 16'h00fd, 4);
      rd(1'b0, 16'h0000, 2);
      // freeze while the bus rests; the pointer must hold
      clk_en <= 1'b0;
      repeat (2 + $urandom % 4) @(posedge mclk);
      check({8'h0, reg_rd_addr}, {8'h0, ptr});
      clk_en <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         i_m.start();
         wb(8'h42 + 8'(k), 1'b0);
         wb(8'h11, 1'b0);
         i_m.stop();
      end
      addr_phase(16'h0030);
      for (int k = 0; k < 4; k++) i_m.bit_io(1'b0, junk);
      i_m.stop();
      rd(1'b0, 16'h0000, 1);
      check(24'(wq.size() + rq.size()), 24'h0);
      results();
   end
endmodule
